// [rtl/mgp_regs.vh]
// Constants for the gigabit PHY-side port: timing, modes, management frame layout
`ifndef MGP_REGS_VH
`define MGP_REGS_VH

// ==========================================================================
// Clock and timing
`define MGP_CLK_KHZ 250000
`define MGP_MDC_MAX_KHZ 2500
// Half period floor in clk cycles: system clock over twice the pin clock ceiling
`define MGP_MDC_MIN_HALF 50
`define MGP_SYNC_STAGES 3

// ==========================================================================
// Link speed codes carried in the serial stream
`define MGP_SPEED_10 2'b00
`define MGP_SPEED_100 2'b01
`define MGP_SPEED_1000 2'b10
`define MGP_REP_10 100
`define MGP_REP_100 10
`define MGP_REP_1000 1

// ==========================================================================
// SerDes reference clock choices, kHz, and select codes
`define MGP_REF_125 125000
`define MGP_REF_156 156250
`define MGP_REF_312 312500
`define MGP_REFSEL_125 2'b00
`define MGP_REFSEL_156 2'b01
`define MGP_REFSEL_312 2'b10
`define MGP_REFSEL_BAD 2'b11

// ==========================================================================
// Management frame: 32 preamble bits then 32 frame bits
`define MGP_MD_BITS 64
`define MGP_MD_TA_BIT 47
`define MGP_MD_DATA_BIT 48
`define MGP_MD_START 2'b01
`define MGP_MD_OP_WRITE 2'b01
`define MGP_MD_OP_READ 2'b10
`define MGP_MD_TA 2'b10

// ==========================================================================
// Descriptor memory
`define MGP_DESC_AW 11
`define MGP_DESC_WORDS 2048

`endif

// [rtl/mgp_fifo.v]
// Synchronous valid/ready FIFO with parameter width and depth
`timescale 1ns/10ps
module mgp_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire resetn,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output reg in_ready,
  output reg [WIDTH-1:0] out_data,
  output reg out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire take;
  wire pop;
  wire [AW:0] next_count;

  // ==========================================================================
  // Output stage is a register fed from storage, so reads stay flopped
  assign push = in_valid && in_ready;
  assign take = out_valid && out_ready;
  assign pop = (count != {(AW+1){1'b0}}) && (!out_valid || take);
  assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always @(posedge clk) begin
    if (!resetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        out_data <= mem[rd_ptr];
        rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
        out_valid <= 1'b1;
      end else if (take) begin
        out_valid <= 1'b0;
      end
      count <= next_count;
      // Registered ready: one slot of slack is given up to keep it a flop
      in_ready <= (next_count < DEPTH - 1);
    end
  end
endmodule

// [rtl/mgp_port.v]
// PHY-side port: byte/nibble media interface, serial gasket, management pin, descriptor RAM
`timescale 1ns/10ps
`include "mgp_regs.vh"
module mgp_port #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3,
  parameter REFCLK_KHZ = `MGP_REF_125
) (
  input wire clk,
  input wire resetn,
  input wire [7:0] tx_in_data,
  input wire tx_in_last,
  input wire tx_in_valid,
  output wire tx_in_ready,
  input wire phy_tx_clock,
  input wire gigabit_tx_clock,
  output reg [7:0] tx_data_bus,
  output reg tx_data_enable,
  output reg tx_aborted,
  input wire phy_rx_clock,
  input wire [7:0] rx_data_bus,
  input wire rx_data_valid,
  input wire rx_error_flag,
  output reg [7:0] rx_out_data,
  output reg rx_out_valid,
  output reg rx_out_end,
  output reg rx_out_error,
  input wire collision_detect,
  input wire carrier_sense,
  input wire external_duplex_select,
  input wire external_gigabit_select,
  output reg half_duplex_active,
  input wire serdes_word_tick,
  input wire [1:0] sg_speed_in,
  input wire sg_speed_strobe,
  output reg [1:0] sg_speed,
  output reg [7:0] sg_tx_data,
  output reg sg_tx_en,
  output reg sg_tx_strobe,
  output reg [1:0] refclk_select,
  input wire [7:0] mgmt_clock_divider,
  input wire mgmt_start,
  input wire mgmt_write,
  input wire [4:0] mgmt_phy_addr,
  input wire [4:0] mgmt_reg_addr,
  input wire [15:0] mgmt_wdata,
  output reg mgmt_busy,
  output reg mgmt_done,
  output reg [15:0] mgmt_rdata,
  output reg mgmt_clock_out,
  input wire mdio_in,
  output reg mdio_out,
  output reg mdio_oe,
  output reg mdio_oe_n,
  input wire cpu_ram_en,
  input wire cpu_ram_we,
  input wire [`MGP_DESC_AW-1:0] cpu_ram_addr,
  input wire [31:0] cpu_ram_wdata,
  output reg [31:0] cpu_ram_rdata,
  input wire desc_req,
  input wire desc_in_proc_mem,
  input wire [31:0] desc_addr,
  output reg desc_valid,
  output reg [31:0] desc_word,
  output reg proc_req,
  output reg [31:0] proc_addr,
  input wire proc_rvalid,
  input wire [31:0] proc_rdata,
  input wire mac_ram_we,
  input wire [`MGP_DESC_AW-1:0] mac_ram_addr,
  input wire [31:0] mac_ram_wdata
);
  // ==========================================================================
  // Mode selection and asynchronous input synchronisers
  reg [`MGP_SYNC_STAGES-1:0] col_sync;
  reg [`MGP_SYNC_STAGES-1:0] crs_sync;
  wire col_seen;
  wire crs_seen;
  wire gig_mode;

  assign gig_mode = external_gigabit_select;
  assign col_seen = col_sync[`MGP_SYNC_STAGES-1] && half_duplex_active;
  assign crs_seen = crs_sync[`MGP_SYNC_STAGES-1] && half_duplex_active;

  always @(posedge clk) begin
    if (!resetn) begin
      col_sync <= {`MGP_SYNC_STAGES{1'b0}};
      crs_sync <= {`MGP_SYNC_STAGES{1'b0}};
      half_duplex_active <= 1'b0;
    end else begin
      col_sync <= {col_sync[`MGP_SYNC_STAGES-2:0], collision_detect};
      crs_sync <= {crs_sync[`MGP_SYNC_STAGES-2:0], carrier_sense};
      // Gigabit forces full duplex whatever the strap says
      half_duplex_active <= !external_duplex_select && !gig_mode;
    end
  end

  // ==========================================================================
  // Media clock edges; the PHY clocks arrive as sampled levels
  reg ptx_q;
  reg gtx_q;
  reg prx_q;
  wire tx_tick;
  wire rx_tick;
  assign tx_tick = gig_mode ? (gigabit_tx_clock && !gtx_q) : (phy_tx_clock && !ptx_q);
  assign rx_tick = phy_rx_clock && !prx_q;

  always @(posedge clk) begin
    if (!resetn) begin
      ptx_q <= 1'b0;
      gtx_q <= 1'b0;
      prx_q <= 1'b0;
    end else begin
      ptx_q <= phy_tx_clock;
      gtx_q <= gigabit_tx_clock;
      prx_q <= phy_rx_clock;
    end
  end

  // ==========================================================================
  // Transmit: FIFO then byte or two-nibble serialiser
  wire [8:0] fifo_out;
  wire fifo_valid;
  reg fifo_take;
  reg tx_hi;
  reg tx_drop;

  mgp_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_tx_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_data({tx_in_last, tx_in_data}),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(fifo_take)
  );

  always @* begin
    fifo_take = 1'b0;
    if (tx_drop) begin
      fifo_take = 1'b1;
    end else if (tx_tick && fifo_valid && (gig_mode || tx_hi)) begin
      // Defer a fresh frame while the line is busy in half duplex
      fifo_take = tx_data_enable || !crs_seen;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      tx_data_bus <= 8'h00;
      tx_data_enable <= 1'b0;
      tx_hi <= 1'b0;
      tx_drop <= 1'b0;
      tx_aborted <= 1'b0;
    end else begin
      tx_aborted <= 1'b0;
      if (tx_drop) begin
        if (fifo_valid && fifo_out[8]) begin
          tx_drop <= 1'b0;
        end
      end else if (tx_data_enable && col_seen) begin
        // Collision ends our frame; the rest of it is flushed
        tx_data_enable <= 1'b0;
        tx_hi <= 1'b0;
        tx_aborted <= 1'b1;
        // The tail byte is gone only if this very cycle takes it
        tx_drop <= !(fifo_take && fifo_out[8]);
      end else if (tx_tick) begin
        if (fifo_valid && (tx_data_enable || !crs_seen)) begin
          tx_data_enable <= 1'b1;
          if (gig_mode) begin
            tx_data_bus <= fifo_out[7:0];
          end else begin
            tx_data_bus <= {4'h0, tx_hi ? fifo_out[7:4] : fifo_out[3:0]};
            tx_hi <= !tx_hi;
          end
        end else begin
          tx_data_enable <= 1'b0;
          tx_data_bus <= 8'h00;
          tx_hi <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Receive: byte or low-nibble-first assembly, error caught only in frame
  reg rx_in_frame;
  reg rx_half;
  reg [3:0] rx_low;
  reg rx_err_seen;

  always @(posedge clk) begin
    if (!resetn) begin
      rx_in_frame <= 1'b0;
      rx_half <= 1'b0;
      rx_low <= 4'h0;
      rx_err_seen <= 1'b0;
      rx_out_data <= 8'h00;
      rx_out_valid <= 1'b0;
      rx_out_end <= 1'b0;
      rx_out_error <= 1'b0;
    end else begin
      rx_out_valid <= 1'b0;
      rx_out_end <= 1'b0;
      if (rx_tick) begin
        if (rx_data_valid) begin
          rx_in_frame <= 1'b1;
          if (rx_error_flag) begin
            rx_err_seen <= 1'b1;
          end
          if (gig_mode) begin
            rx_out_data <= rx_data_bus;
            rx_out_valid <= 1'b1;
          end else if (rx_half) begin
            rx_out_data <= {rx_data_bus[3:0], rx_low};
            rx_out_valid <= 1'b1;
            rx_half <= 1'b0;
          end else begin
            rx_low <= rx_data_bus[3:0];
            rx_half <= 1'b1;
          end
        end else if (rx_in_frame) begin
          // Error outside valid is ignored; odd final nibble is marked bad
          rx_in_frame <= 1'b0;
          rx_out_end <= 1'b1;
          rx_out_error <= rx_err_seen || rx_half;
          rx_err_seen <= 1'b0;
          rx_half <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Serial gasket: speed from the stream, repetition paced by SerDes ticks
  reg [6:0] sg_rep;
  reg [6:0] sg_rep_cnt;
  reg [7:0] sg_hold;
  reg sg_hold_en;

  always @* begin
    case (sg_speed)
      `MGP_SPEED_10: sg_rep = 7'd`MGP_REP_10;
      `MGP_SPEED_100: sg_rep = 7'd`MGP_REP_100;
      default: sg_rep = 7'd`MGP_REP_1000;
    endcase
  end

  always @(posedge clk) begin
    if (!resetn) begin
      sg_speed <= `MGP_SPEED_1000;
      sg_rep_cnt <= 7'd0;
      sg_hold <= 8'h00;
      sg_hold_en <= 1'b0;
      sg_tx_data <= 8'h00;
      sg_tx_en <= 1'b0;
      sg_tx_strobe <= 1'b0;
    end else begin
      sg_tx_strobe <= 1'b0;
      if (sg_speed_strobe && sg_speed_in != 2'b11) begin
        sg_speed <= sg_speed_in;
        sg_rep_cnt <= 7'd0;
      end
      if (tx_tick) begin
        sg_hold <= tx_data_bus;
        sg_hold_en <= tx_data_enable;
      end
      if (serdes_word_tick) begin
        sg_tx_strobe <= 1'b1;
        if (sg_rep_cnt == 7'd0) begin
          sg_tx_data <= sg_hold;
          sg_tx_en <= sg_hold_en;
        end
        // Same item stands for all repeats of one slow-rate phase
        sg_rep_cnt <= (sg_rep_cnt >= sg_rep - 7'd1) ? 7'd0 : sg_rep_cnt + 7'd1;
      end
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      refclk_select <= `MGP_REFSEL_BAD;
    end else begin
      case (REFCLK_KHZ)
        `MGP_REF_125: refclk_select <= `MGP_REFSEL_125;
        `MGP_REF_156: refclk_select <= `MGP_REFSEL_156;
        `MGP_REF_312: refclk_select <= `MGP_REFSEL_312;
        default: refclk_select <= `MGP_REFSEL_BAD;
      endcase
    end
  end

  // ==========================================================================
  // Management interface: clock divider and frame shifter
  localparam MD_IDLE = 2'b01;
  localparam MD_RUN = 2'b10;
  reg [1:0] md_state;
  reg [7:0] md_div_cnt;
  reg [6:0] md_bit;
  reg [63:0] md_shift;
  reg md_read;
  wire [7:0] md_half;
  wire md_release;

  // Floor keeps the pin clock at or below its ceiling whatever is programmed
  assign md_half = (mgmt_clock_divider < 8'd`MGP_MDC_MIN_HALF) ? 8'd`MGP_MDC_MIN_HALF : mgmt_clock_divider;
  assign md_release = md_read && (md_bit >= 7'd`MGP_MD_TA_BIT);

  always @(posedge clk) begin
    if (!resetn) begin
      md_state <= MD_IDLE;
      md_div_cnt <= 8'h00;
      md_bit <= 7'd0;
      md_shift <= 64'h0;
      md_read <= 1'b0;
      mgmt_busy <= 1'b0;
      mgmt_done <= 1'b0;
      mgmt_rdata <= 16'h0000;
      mgmt_clock_out <= 1'b0;
      mdio_out <= 1'b1;
      mdio_oe <= 1'b0;
      mdio_oe_n <= 1'b1;
    end else begin
      mgmt_done <= 1'b0;
      case (md_state)
        MD_IDLE: begin
          mgmt_clock_out <= 1'b0;
          mdio_oe <= 1'b0;
          mdio_oe_n <= 1'b1;
          if (mgmt_start) begin
            md_shift <= {32'hffffffff, `MGP_MD_START, mgmt_write ? `MGP_MD_OP_WRITE : `MGP_MD_OP_READ,
                         mgmt_phy_addr, mgmt_reg_addr, `MGP_MD_TA, mgmt_write ? mgmt_wdata : 16'h0000};
            md_read <= !mgmt_write;
            md_bit <= 7'd0;
            md_div_cnt <= 8'h00;
            mgmt_busy <= 1'b1;
            // Preamble is driven from the first busy cycle on
            mdio_out <= 1'b1;
            mdio_oe <= 1'b1;
            mdio_oe_n <= 1'b0;
            md_state <= MD_RUN;
          end
        end
        MD_RUN: begin
          if (md_div_cnt == md_half - 8'd1) begin
            md_div_cnt <= 8'h00;
            mgmt_clock_out <= !mgmt_clock_out;
            if (!mgmt_clock_out) begin
              // Rising pin clock: PHY samples our bit, we sample read data
              if (md_read && md_bit >= 7'd`MGP_MD_DATA_BIT) begin
                mgmt_rdata <= {mgmt_rdata[14:0], mdio_in};
              end
            end else begin
              if (md_bit == 7'd`MGP_MD_BITS - 7'd1) begin
                md_state <= MD_IDLE;
                mgmt_busy <= 1'b0;
                mgmt_done <= 1'b1;
                mdio_oe <= 1'b0;
                mdio_oe_n <= 1'b1;
              end else begin
                md_bit <= md_bit + 7'd1;
                md_shift <= {md_shift[62:0], 1'b0};
              end
            end
          end else begin
            md_div_cnt <= md_div_cnt + 8'd1;
          end
          if (!(mgmt_clock_out && md_div_cnt == md_half - 8'd1 && md_bit == 7'd`MGP_MD_BITS - 7'd1)) begin
            mdio_out <= md_shift[63];
            mdio_oe <= !md_release;
            mdio_oe_n <= md_release;
          end
        end
        default: begin
          md_state <= MD_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Descriptor RAM and fetch path
  reg [31:0] desc_ram [0:`MGP_DESC_WORDS-1];
  reg local_pend;
  reg proc_pend;

  always @(posedge clk) begin
    // CPU write wins a same-address collision with the MAC
    if (cpu_ram_en && cpu_ram_we) begin
      desc_ram[cpu_ram_addr] <= cpu_ram_wdata;
    end
    if (mac_ram_we && !(cpu_ram_en && cpu_ram_we && cpu_ram_addr == mac_ram_addr)) begin
      desc_ram[mac_ram_addr] <= mac_ram_wdata;
    end
    cpu_ram_rdata <= desc_ram[cpu_ram_addr];
    desc_word <= proc_pend ? proc_rdata : desc_ram[desc_addr[`MGP_DESC_AW+1:2]];
  end

  always @(posedge clk) begin
    if (!resetn) begin
      local_pend <= 1'b0;
      proc_pend <= 1'b0;
      desc_valid <= 1'b0;
      proc_req <= 1'b0;
      proc_addr <= 32'h0;
    end else begin
      desc_valid <= 1'b0;
      proc_req <= 1'b0;
      if (local_pend) begin
        local_pend <= 1'b0;
        desc_valid <= 1'b1;
      end else if (proc_pend) begin
        if (proc_rvalid) begin
          proc_pend <= 1'b0;
          desc_valid <= 1'b1;
        end
      end else if (desc_req) begin
        if (desc_in_proc_mem) begin
          proc_req <= 1'b1;
          proc_addr <= desc_addr;
          proc_pend <= 1'b1;
        end else begin
          local_pend <= 1'b1;
        end
      end
    end
  end
endmodule

// [testbench/mgp_port_props.sv]
// Concurrent checks on the ports of the PHY-side port
`timescale 1ns/10ps
module mgp_port_props (
  input wire clk,
  input wire resetn,
  input wire [7:0] tx_data_bus,
  input wire tx_data_enable,
  input wire external_gigabit_select,
  input wire half_duplex_active,
  input wire [1:0] sg_speed_in,
  input wire sg_speed_strobe,
  input wire [1:0] sg_speed,
  input wire desc_req,
  input wire desc_in_proc_mem,
  input wire desc_valid,
  input wire proc_req,
  input wire mgmt_start,
  input wire mgmt_busy,
  input wire mdio_oe,
  input wire mdio_oe_n,
  input wire mgmt_clock_out,
  input wire rx_out_valid
);
  // ==========================================================================
  // Assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_oe_pair: assert property (mdio_oe_n == !mdio_oe)
    else $error("management enable pair disagrees");
  chk_gig_full: assert property (external_gigabit_select [*2] |-> !half_duplex_active)
    else $error("half duplex in gigabit mode");
  // Mode only changes while idle, so three cycles settle it
  chk_nibble_hi: assert property (!external_gigabit_select [*3] ##0 tx_data_enable |-> tx_data_bus[7:4] == 4'h0)
    else $error("upper nibble moves in nibble mode");
  chk_speed_take: assert property (sg_speed_strobe && sg_speed_in != 2'b11 |=> sg_speed == $past(sg_speed_in))
    else $error("speed update not taken");
  chk_speed_keep: assert property (!sg_speed_strobe || sg_speed_in == 2'b11 |=> $stable(sg_speed))
    else $error("speed changed without update");
  chk_local_fetch: assert property (desc_req && !desc_in_proc_mem |-> ##2 desc_valid)
    else $error("local descriptor late");
  chk_proc_fetch: assert property (desc_req && desc_in_proc_mem |=> proc_req)
    else $error("processor fetch not issued");
  chk_mgmt_take: assert property (mgmt_start && !mgmt_busy |=> mgmt_busy && mdio_oe)
    else $error("management frame not started");
  chk_mdc_slow: assert property ($rose(mgmt_clock_out) |=> $stable(mgmt_clock_out) [*8])
    else $error("management clock too fast");
  chk_rx_pulse: assert property (rx_out_valid |=> !rx_out_valid)
    else $error("receive byte pulse too long");
endmodule
bind mgp_port mgp_port_props chk (.*);

// [testbench/mgp_phy_model.sv]
// Behavioural PHY on the far side of the media and management pins
`timescale 1ns/10ps
module mgp_phy_model (
  input wire clk,
  input wire [7:0] tx_data_bus,
  input wire tx_data_enable,
  input wire mgmt_clock_out,
  input wire mdio_out,
  input wire mdio_oe,
  input wire mgmt_busy,
  output reg phy_tx_clock,
  output reg [7:0] rx_data_bus,
  output reg rx_data_valid,
  output reg rx_error_flag,
  output wire mdio_in
);
  integer hp, ph, cnt;
  reg [7:0] got[$];
  reg [63:0] fr;
  reg [15:0] rd_word;
  reg mdc_q;
  initial begin
    {phy_tx_clock, rx_data_bus, rx_data_valid, rx_error_flag, mdc_q, fr, rd_word} = 0;
    hp = 1;
    ph = 0;
    cnt = 17;
  end
  // ==========================================================================
  // Media clock runs free; transmit bus taken at each rise
  always @(posedge clk) begin
    if (ph >= hp - 1) begin
      ph = 0;
      if (!phy_tx_clock && tx_data_enable) got.push_back(tx_data_bus);
      #1 phy_tx_clock = ~phy_tx_clock;
    end else begin
      ph = ph + 1;
    end
  end
  task rx_send(input [7:0] b, input v, input e);
    begin
      @(negedge phy_tx_clock);
      rx_data_bus = b;
      rx_data_valid = v;
      rx_error_flag = e;
    end
  endtask
  // ==========================================================================
  // Management pin: pull-up when released, read data after each rising clock
  assign mdio_in = mdio_oe ? mdio_out : (!mgmt_busy || cnt > 16) ? 1'b1 : (cnt == 0) ? 1'b0 : rd_word[16 - cnt];
  always @(posedge clk) begin
    mdc_q <= mgmt_clock_out;
    if (mdio_oe) cnt <= 0;
    else if (mgmt_clock_out && !mdc_q) cnt <= cnt + 1;
    if (mdio_oe && mgmt_clock_out && !mdc_q) fr <= {fr[62:0], mdio_out};
  end
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the PHY-side port
`timescale 1ns/10ps
`include "mgp_regs.vh"
module testbench;
  reg clk, resetn, tx_in_last, tx_in_valid, collision_detect, carrier_sense, serdes_word_tick, sg_speed_strobe;
  reg external_duplex_select, external_gigabit_select, mgmt_start, mgmt_write, cpu_ram_en, cpu_ram_we;
  reg desc_req, desc_in_proc_mem, proc_rvalid, mac_ram_we, full, rerr;
  reg [1:0] sg_speed_in;
  reg [4:0] mgmt_phy_addr, mgmt_reg_addr;
  reg [7:0] tx_in_data, mgmt_clock_divider, b, exq[$], rq[$];
  reg [10:0] cpu_ram_addr, mac_ram_addr;
  reg [15:0] mgmt_wdata;
  reg [31:0] cpu_ram_wdata, desc_addr, proc_rdata, mac_ram_wdata, w, v;
  wire phy_tx_clock, gigabit_tx_clock, phy_rx_clock, rx_data_valid, rx_error_flag, mdio_in, tx_in_ready;
  wire tx_data_enable, tx_aborted, rx_out_valid, rx_out_end, rx_out_error, half_duplex_active, sg_tx_en;
  wire sg_tx_strobe, mgmt_busy, mgmt_done, mgmt_clock_out, mdio_out, mdio_oe, mdio_oe_n, desc_valid, proc_req;
  wire [1:0] sg_speed, refclk_select;
  wire [7:0] rx_data_bus, tx_data_bus, rx_out_data, sg_tx_data;
  wire [15:0] mgmt_rdata;
  wire [31:0] cpu_ram_rdata, desc_word, proc_addr;
  integer seed, bad_count, tests_run, cyc, i, t, m;
  assign gigabit_tx_clock = phy_tx_clock;
  assign phy_rx_clock = phy_tx_clock;
  mgp_port dut (.*);
  mgp_phy_model p (.*);
  // ==========================================================================
  // Helpers
  task chk(input [63:0] got, input [63:0] exp, input [8*12-1:0] msg);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: %0s got %h expected %h", $time, msg, got, exp);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task final_report;
    begin
      if (bad_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task wait_hi(input sel);
    begin
      t = 0;
      while (((sel ? proc_req : desc_valid) !== 1'b1) && t < 8) begin
        tick(1);
        t = t + 1;
      end
    end
  endtask
  task tx_frame(input gig, input integer n);
    begin
      external_gigabit_select = gig;
      p.hp = gig ? 1 : 5;
      full = 0;
      for (i = 0; i < n; i = i + 1) begin
        b = $random(seed);
        if (gig) exq.push_back(b);
        else begin
          exq.push_back({4'h0, b[3:0]});
          exq.push_back({4'h0, b[7:4]});
        end
        {tx_in_data, tx_in_last, tx_in_valid} = {b, i == n - 1, 1'b1};
        m = 0;
        while (m == 0) begin
          m = tx_in_ready === 1'b1;
          if (!m) full = 1;
          tick(1);
        end
      end
      tx_in_valid = 0;
      t = 0;
      while ((p.got.size() < exq.size() || tx_data_enable !== 1'b0) && t < 2000) begin
        tick(1);
        t = t + 1;
      end
      chk(p.got.size(), exq.size(), "tx count");
      for (i = 0; i < exq.size(); i = i + 1) chk(p.got[i], exq[i], "tx byte");
      if (!gig) chk(full, 1, "fifo refuse");
      exq.delete();
      p.got.delete();
      tick(12);
    end
  endtask
  task rx_frame(input gig, input integer n, input e);
    begin
      external_gigabit_select = gig;
      p.hp = gig ? 1 : 5;
      rerr = ~e;
      p.rx_send(8'h5a, 0, 1);
      for (i = 0; i < n; i = i + 1) begin
        b = $random(seed);
        exq.push_back(b);
        if (gig) p.rx_send(b, 1, e && i == 1);
        else begin
          p.rx_send(b, 1, e && i == 1);
          p.rx_send({b[3:0], b[7:4]}, 1, 0);
        end
      end
      p.rx_send(~b, 0, 0);
      tick(30);
      chk(rq.size(), n, "rx count");
      for (i = 0; i < n; i = i + 1) chk(rq[i], exq[i], "rx byte");
      chk(rerr, e, "rx error");
      exq.delete();
      rq.delete();
    end
  endtask
  task mgmt(input wr);
    begin
      {mgmt_phy_addr, mgmt_reg_addr, mgmt_wdata} = $random(seed);
      p.rd_word = $random(seed);
      {mgmt_write, mgmt_start} = {wr, 1'b1};
      tick(1);
      mgmt_start = 0;
      t = 0;
      while (mgmt_done !== 1'b1 && t < 9000) begin
        tick(1);
        t = t + 1;
      end
      chk(mgmt_done, 1, "mgmt done");
      if (wr) chk(p.fr, {32'hffffffff, `MGP_MD_START, `MGP_MD_OP_WRITE, mgmt_phy_addr, mgmt_reg_addr,
        `MGP_MD_TA, mgmt_wdata}, "write frame");
      else begin
        chk(p.fr[46:0], {32'hffffffff, `MGP_MD_START, `MGP_MD_OP_READ, mgmt_phy_addr, mgmt_reg_addr, 1'b1},
          "read frame");
        chk(mgmt_rdata, p.rd_word, "read data");
      end
    end
  endtask
  // ==========================================================================
  // Clock, capture and hang limit
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    serdes_word_tick <= #1 ~serdes_word_tick;
    if (rx_out_valid === 1'b1) rq.push_back(rx_out_data);
    if (rx_out_end === 1'b1) rerr = rx_out_error;
    cyc = cyc + 1;
    if (cyc == 40000) begin
      bad_count = bad_count + 1;
      final_report;
    end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    {resetn, tx_in_last, tx_in_valid, collision_detect, carrier_sense, serdes_word_tick, sg_speed_strobe,
      external_gigabit_select, mgmt_start, mgmt_write, cpu_ram_en, cpu_ram_we, desc_req, desc_in_proc_mem,
      proc_rvalid, mac_ram_we, sg_speed_in, mgmt_phy_addr, mgmt_reg_addr, tx_in_data, cpu_ram_addr,
      mac_ram_addr, mgmt_wdata, cpu_ram_wdata, desc_addr, proc_rdata, mac_ram_wdata} = 0;
    {seed, bad_count, tests_run, cyc, external_duplex_select} = {32'd1634, 96'd0, 1'b1};
    mgmt_clock_divider = 8'h32 + ($random(seed) & 7);
    tick(20);
    resetn = 1;
    tick(1);
    chk(mdio_oe_n, 1, "oe idle");
    chk(refclk_select, `MGP_REFSEL_125, "refclk");
    chk(sg_speed, `MGP_SPEED_1000, "speed rst");
    external_duplex_select = 0;
    tick(3);
    chk(half_duplex_active, 1, "half dup");
    external_gigabit_select = 1;
    tick(3);
    chk(half_duplex_active, 0, "gig full");
    external_duplex_select = 1;
    m = 2;
    for (i = 0; i < 4; i = i + 1) begin
      {sg_speed_in, sg_speed_strobe} = {i[1:0], 1'b1};
      if (i < 3) m = i;
      tick(1);
      sg_speed_strobe = 0;
      tick(1);
      chk(sg_speed, m, "speed");
    end
    repeat (4) begin
      cpu_ram_addr = $random(seed);
      {cpu_ram_wdata, mac_ram_wdata, mac_ram_addr} = {$random(seed), $random(seed), cpu_ram_addr};
      {cpu_ram_en, cpu_ram_we, mac_ram_we, w} = {3'b111, cpu_ram_wdata};
      tick(1);
      {cpu_ram_we, mac_ram_addr, mac_ram_wdata} = {1'b0, cpu_ram_addr + 11'h1, $random(seed)};
      v = mac_ram_wdata;
      tick(1);
      {cpu_ram_en, mac_ram_we} = 2'b00;
      chk(cpu_ram_rdata, w, "cpu wins");
      {desc_in_proc_mem, desc_addr, desc_req} = {1'b0, 19'h0, mac_ram_addr, 2'b00, 1'b1};
      tick(1);
      desc_req = 0;
      wait_hi(0);
      chk(desc_word, v, "local desc");
      {desc_in_proc_mem, desc_addr, desc_req} = {1'b1, $random(seed), 1'b1};
      tick(1);
      desc_req = 0;
      wait_hi(1);
      chk(proc_addr, desc_addr, "proc addr");
      {proc_rvalid, proc_rdata} = {1'b1, $random(seed)};
      tick(1);
      proc_rvalid = 0;
      wait_hi(0);
      chk(desc_word, proc_rdata, "proc desc");
    end
    tx_frame(1, 10);
    tx_frame(0, 12);
    rx_frame(1, 6, 0);
    rx_frame(0, 5, 1);
    {external_duplex_select, tx_in_data, tx_in_last, tx_in_valid} = 11'h3ff;
    tick(1);
    tx_in_valid = 0;
    t = 0;
    while (tx_data_enable !== 1'b1 && t < 40) begin
      tick(1);
      t = t + 1;
    end
    collision_detect = 1;
    tick(4);
    chk(tx_aborted, 1, "col abort");
    chk(tx_data_enable, 0, "col stop");
    collision_detect = 0;
    tick(12);
    chk(tx_data_enable, 0, "col flush");
    external_duplex_select = 1;
    mgmt(1);
    mgmt(0);
    final_report;
  end
endmodule
